// >>> pkg/dcc_pkg.sv
// dcc_pkg: register map, field positions and engine encodings of the
// dma channel control block; shared by the control module and its decoder.
package dcc_pkg;

  // global registers (byte addresses)
  localparam logic [11:0] DCC_GE = 12'h000;
  localparam logic [11:0] DCC_GD = 12'h004;
  localparam logic [11:0] DCC_GS = 12'h008;
  localparam logic [11:0] DCC_GIE = 12'h00c;
  // channel n occupies DCC_CH_BASE * (n + 1) .. + 12'h03f
  localparam logic [11:0] DCC_CH_BASE = 12'h040;
  localparam logic [5:0] DCC_CIE = 6'h00;
  localparam logic [5:0] DCC_CIS = 6'h04;
  localparam logic [5:0] DCC_CNDA = 6'h08;
  localparam logic [5:0] DCC_CNDC = 6'h0c;
  localparam logic [5:0] DCC_CSA = 6'h10;
  localparam logic [5:0] DCC_CDA = 6'h14;
  localparam logic [5:0] DCC_CBC = 6'h18;
  localparam logic [5:0] DCC_CDSM = 6'h1c;
  localparam logic [5:0] DCC_CSUS = 6'h20;
  localparam logic [5:0] DCC_CDUS = 6'h24;

  // next_descriptor_control_reg fields
  localparam int DCC_NDC_FE = 0;
  localparam int DCC_NDC_SUP = 1;
  localparam int DCC_NDC_DUP = 2;
  localparam int DCC_NDC_VIEW = 3;
  // channel irq status / enable bits
  localparam int DCC_IRQ_BLK = 0;
  localparam int DCC_IRQ_LST = 1;
  // descriptor_microblock_control word fields
  localparam int DCC_UBC_NDE = 24;
  localparam int DCC_UBC_VIEW = 27;
  localparam int DCC_BLOCK_LENGTH_W = 24;
  localparam logic [31:0] DCC_RESET_WORD = 32'h0000_0000;

  // index of the last word of a descriptor for each view
  localparam logic [2:0] DCC_VIEW0_LAST = 3'h1;
  localparam logic [2:0] DCC_VIEW1_LAST = 3'h2;
  localparam logic [2:0] DCC_VIEW2_LAST = 3'h3;
  localparam logic [2:0] DCC_VIEW3_LAST = 3'h4;

  typedef enum logic [2:0] {
    DCC_ROLE_NDA = 3'h0,
    DCC_ROLE_UBC = 3'h1,
    DCC_ROLE_SRC = 3'h2,
    DCC_ROLE_DST = 3'h3,
    DCC_ROLE_BLOCK_LENGTH = 3'h4
  } dcc_role_t;

  typedef enum logic [1:0] {
    DCC_E_IDLE = 2'b00,
    DCC_E_FETCH = 2'b01,
    DCC_E_MOVE = 2'b11
  } dcc_eng_t;

endpackage

// >>> verilog/dcc_view_decode.sv
// dcc_view_decode: maps a descriptor view and a word index to the
// role of that word and the index of the view's last word.
// assumes idx never runs past last_idx; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module dcc_view_decode
  import dcc_pkg::*;
(
  input wire logic [1:0] view,
  input wire logic [2:0] idx,
  output logic [2:0] last_idx,
  output dcc_pkg::dcc_role_t role
);

  // longer views append words, so the role depends only on the index
  always_comb
  begin
    case (view)
      2'h0: last_idx = DCC_VIEW0_LAST;
      2'h1: last_idx = DCC_VIEW1_LAST;
      2'h2: last_idx = DCC_VIEW2_LAST;
      default: last_idx = DCC_VIEW3_LAST;
    endcase
    case (idx)
      3'h0: role = DCC_ROLE_NDA;
      3'h1: role = DCC_ROLE_UBC;
      3'h2: role = DCC_ROLE_SRC;
      3'h3: role = DCC_ROLE_DST;
      default: role = DCC_ROLE_BLOCK_LENGTH;
    endcase
  end

endmodule
`default_nettype wire

// >>> verilog/dcc_channel_ctrl.sv
// dcc_channel_ctrl: apb register file and shared engine of a multi
// channel dma controller: descriptor fetch, microblock moves, status, irq.
// assumes an apb master, a memory port answering fetch_req with one
// fetch_ack pulse per word and a mover answering move_req with move_done.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - reading channel irq status clears its pending bits
// - each descriptor is decoded by the view chosen for it
// - a descriptor with next-enable zero ends the list, no more fetches
// - next descriptor address holds first pointer and master select bit
// - descriptors are fetched only while descriptor fetch enable is set
// - source update set loads source address from each descriptor
// - destination update set loads destination address from each descriptor
// - view field of next descriptor control sizes the first fetch
// - block length gives microblocks moved before end of block; zero moves one
// - control and stride registers at zero mean no list, no striding
// - block irq needs channel enable and global channel gate both set
// - channel offers an end of list irq enabled by its enable bit
// - writing one to a global enable bit starts channel, sets status
// - block completion sets end of block flag, irq only when enabled and gated; last block clears global status
// - global disable write stops channel; status clears when it halts
module dcc_channel_ctrl
  import dcc_pkg::*;
#(
  parameter int NCH = 4,
  localparam int CW = $clog2(NCH)
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  output logic fetch_if,
  input wire logic fetch_ack,
  input wire logic [31:0] fetch_data,
  output logic move_req,
  output logic [CW-1:0] move_chan,
  output logic [31:0] move_src,
  output logic [31:0] move_dst,
  input wire logic move_done
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic fetch_req;
    logic [31:0] fetch_addr;
    logic fetch_if;
    logic move_req;
    logic [CW-1:0] move_chan;
    logic [31:0] move_src;
    logic [31:0] move_dst;
    dcc_eng_t eng;
    logic [CW-1:0] cur;
    logic [2:0] widx;
    logic [1:0] view;
    logic [1:0] nview;
    logic last_desc;
    logic list_mode;
    logic abort;
    logic [DCC_BLOCK_LENGTH_W-1:0] mbcnt;
    logic [NCH-1:0] gs;
    logic [NCH-1:0] gie;
    logic [NCH-1:0][1:0] cie;
    logic [NCH-1:0][1:0] cis;
    logic [NCH-1:0][4:0] ndc;
    logic [NCH-1:0][DCC_BLOCK_LENGTH_W-1:0] block_length;
    logic [NCH-1:0][31:0] next_descriptor_pointer;
    logic [NCH-1:0][31:0] sa;
    logic [NCH-1:0][31:0] da;
    logic [NCH-1:0][31:0] dsm;
    logic [NCH-1:0][31:0] sus;
    logic [NCH-1:0][31:0] dus;
  } dcc_state_t;

  dcc_state_t st;
  dcc_state_t next_st;
  logic acc, rd, wr, hit;
  logic [CW-1:0] wch;
  logic [6:0] chx;
  logic [NCH-1:0] ge_w, gd_w, pend;
  logic [2:0] wlast;
  dcc_role_t role;

  // channel window decode, shared by the read and the write paths
  function automatic logic [6:0] chan_hit(input logic [11:0] a);
    logic [5:0] slot;
    slot = a[11:6];
    chan_hit = {(slot != 6'h00) && (int'(slot) <= NCH), slot - 6'h01};
  endfunction

  // lowest numbered pending channel wins the engine
  function automatic logic [CW-1:0] first_one(input logic [NCH-1:0] v);
    first_one = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (v[i])
        first_one = CW'(i);
    end
  endfunction

  function automatic dcc_state_t start_fetch(input dcc_state_t s, input logic [31:0] ptr,
                                             input logic [1:0] view);
    s.fetch_req = 1'b1;
    s.fetch_addr = {ptr[31:2], 2'b00};
    s.fetch_if = ptr[0];
    s.view = view;
    s.widx = 3'h0;
    s.list_mode = 1'b1;
    s.eng = DCC_E_FETCH;
    return s;
  endfunction

  function automatic dcc_state_t start_move(input dcc_state_t s);
    s.mbcnt = '0;
    s.move_req = 1'b1;
    s.move_chan = s.cur;
    s.move_src = s.sa[s.cur];
    s.move_dst = s.da[s.cur];
    s.eng = DCC_E_MOVE;
    return s;
  endfunction

  // channel halts: status drops so software polling sees it stop
  function automatic dcc_state_t finish(input dcc_state_t s);
    s.gs[s.cur] = 1'b0;
    s.fetch_req = 1'b0;
    s.move_req = 1'b0;
    s.abort = 1'b0;
    s.eng = DCC_E_IDLE;
    return s;
  endfunction

  // apb completes in the access cycle after pready was registered high
  assign acc = psel && penable && st.pready;
  assign rd = acc && !pwrite;
  assign wr = acc && pwrite;
  // decoded once; a bit select straight off a call is not legal
  assign chx = chan_hit(paddr);
  assign hit = chx[6];
  assign wch = CW'(chx[5:0]);
  assign ge_w = (wr && paddr == DCC_GE) ? pwdata[NCH-1:0] : '0;
  assign gd_w = (wr && paddr == DCC_GD) ? pwdata[NCH-1:0] : '0;
  assign pend = st.gs & ~gd_w;

  dcc_view_decode u_view (
    .view(st.view),
    .idx(st.widx),
    .last_idx(wlast),
    .role(role)
  );

  // next state: read clears first, then engine events, then bus writes
  always_comb
  begin
    logic [DCC_BLOCK_LENGTH_W-1:0] block_length_eff;
    logic stop;
    logic [NCH-1:0] busy_mask;
    block_length_eff = '0;
    stop = 1'b0;
    busy_mask = '0;
    next_st = st;
    next_st.pready = 1'b0;
    // read clear comes before engine sets, so a same-cycle event survives
    if (rd && hit && paddr[5:0] == DCC_CIS)
      next_st.cis[wch] = 2'b00;
    if (st.eng != DCC_E_IDLE)
    begin
      busy_mask[st.cur] = 1'b1;
      if (gd_w[st.cur])
        next_st.abort = 1'b1;
    end
    stop = st.abort || gd_w[st.cur];
    block_length_eff = (st.block_length[st.cur] == '0) ? DCC_BLOCK_LENGTH_W'(1) : st.block_length[st.cur];
    case (st.eng)
      DCC_E_IDLE:
      begin
        if (pend != '0)
        begin
          next_st.cur = first_one(pend);
          next_st.abort = 1'b0;
          next_st.last_desc = 1'b1;
          next_st.list_mode = 1'b0;
          // fetch enable clear (all-zero control) runs a single block
          if (st.ndc[next_st.cur][DCC_NDC_FE])
            next_st = start_fetch(next_st, st.next_descriptor_pointer[next_st.cur],
                                  st.ndc[next_st.cur][DCC_NDC_VIEW+:2]);
          else
            next_st = start_move(next_st);
        end
      end
      DCC_E_FETCH:
      begin
        if (fetch_ack)
        begin
          case (role)
            DCC_ROLE_NDA: next_st.next_descriptor_pointer[st.cur] = fetch_data;
            DCC_ROLE_UBC:
            begin
              next_st.last_desc = !fetch_data[DCC_UBC_NDE];
              next_st.nview = fetch_data[DCC_UBC_VIEW+:2];
            end
            DCC_ROLE_SRC:
            begin
              if (st.ndc[st.cur][DCC_NDC_SUP])
                next_st.sa[st.cur] = fetch_data;
            end
            DCC_ROLE_DST:
            begin
              if (st.ndc[st.cur][DCC_NDC_DUP])
                next_st.da[st.cur] = fetch_data;
            end
            default: next_st.block_length[st.cur] = fetch_data[DCC_BLOCK_LENGTH_W-1:0];
          endcase
          if (st.widx == wlast)
          begin
            next_st.fetch_req = 1'b0;
            if (stop)
              next_st = finish(next_st);
            else
              next_st = start_move(next_st);
          end
          else
          begin
            next_st.widx = st.widx + 3'h1;
            next_st.fetch_addr = st.fetch_addr + 32'h4;
          end
        end
      end
      DCC_E_MOVE:
      begin
        if (move_done)
        begin
          if (stop)
            next_st = finish(next_st);
          else if (st.mbcnt + DCC_BLOCK_LENGTH_W'(1) >= block_length_eff)
          begin
            next_st.cis[st.cur][DCC_IRQ_BLK] = 1'b1;
            next_st.move_req = 1'b0;
            if (!st.last_desc)
              next_st = start_fetch(next_st, next_st.next_descriptor_pointer[st.cur], st.nview);
            else
            begin
              if (st.list_mode)
                next_st.cis[st.cur][DCC_IRQ_LST] = 1'b1;
              next_st = finish(next_st);
            end
          end
          else
            next_st.mbcnt = st.mbcnt + DCC_BLOCK_LENGTH_W'(1);
        end
      end
      default: next_st.eng = DCC_E_IDLE;
    endcase
    // idle channels stop at once; the busy one waits for its handshake
    next_st.gs = next_st.gs & ~(gd_w & ~busy_mask);
    next_st.gs = next_st.gs | ge_w;
    if (wr && paddr == DCC_GIE)
      next_st.gie = pwdata[NCH-1:0];
    // setup registers are frozen while their channel runs
    if (wr && hit)
    begin
      if (paddr[5:0] == DCC_CIE)
        next_st.cie[wch] = pwdata[1:0];
      else if (!st.gs[wch])
      begin
        case (paddr[5:0])
          DCC_CNDA: next_st.next_descriptor_pointer[wch] = {pwdata[31:2], 1'b0, pwdata[0]};
          DCC_CNDC: next_st.ndc[wch] = pwdata[4:0];
          DCC_CSA: next_st.sa[wch] = pwdata;
          DCC_CDA: next_st.da[wch] = pwdata;
          DCC_CBC: next_st.block_length[wch] = pwdata[DCC_BLOCK_LENGTH_W-1:0];
          DCC_CDSM: next_st.dsm[wch] = pwdata;
          DCC_CSUS: next_st.sus[wch] = pwdata;
          DCC_CDUS: next_st.dus[wch] = pwdata;
          default: next_st.dsm[wch] = st.dsm[wch];
        endcase
      end
    end
    // read data is registered in the setup cycle, zero wait states
    if (psel && !penable)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = 1'b0;
      next_st.prdata = DCC_RESET_WORD;
      if (paddr == DCC_GS)
        next_st.prdata = {{(32 - NCH){1'b0}}, st.gs};
      else if (paddr == DCC_GIE)
        next_st.prdata = {{(32 - NCH){1'b0}}, st.gie};
      else if (paddr == DCC_GE || paddr == DCC_GD)
        next_st.prdata = DCC_RESET_WORD;
      else if (hit)
      begin
        case (paddr[5:0])
          DCC_CIE: next_st.prdata = {30'h0, st.cie[wch]};
          DCC_CIS: next_st.prdata = {30'h0, st.cis[wch]};
          DCC_CNDA: next_st.prdata = st.next_descriptor_pointer[wch];
          DCC_CNDC: next_st.prdata = {27'h0, st.ndc[wch]};
          DCC_CSA: next_st.prdata = st.sa[wch];
          DCC_CDA: next_st.prdata = st.da[wch];
          DCC_CBC: next_st.prdata = {8'h0, st.block_length[wch]};
          DCC_CDSM: next_st.prdata = st.dsm[wch];
          DCC_CSUS: next_st.prdata = st.sus[wch];
          DCC_CDUS: next_st.prdata = st.dus[wch];
          default: next_st.pslverr = 1'b1;
        endcase
      end
      else
        next_st.pslverr = 1'b1;
    end
    // level irq: channel flag, its enable and the global gate
    next_st.irq = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      if (((next_st.cis[i] & next_st.cie[i]) != 2'b00) && next_st.gie[i])
        next_st.irq = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign fetch_req = st.fetch_req;
  assign fetch_addr = st.fetch_addr;
  assign fetch_if = st.fetch_if;
  assign move_req = st.move_req;
  assign move_chan = st.move_chan;
  assign move_src = st.move_src;
  assign move_dst = st.move_dst;

  // checks, all in the single clock domain
  default clocking dcc_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_fetch_gate: assert property (
    st.fetch_req |-> st.ndc[st.cur][DCC_NDC_FE])
    else $error("descriptor fetch while fetch enable is clear");
  a_fetch_hold: assert property (
    st.fetch_req && !fetch_ack |=> st.fetch_req && $stable(st.fetch_addr))
    else $error("fetch request dropped or moved before ack");
  a_start_sets: assert property (
    wr && paddr == DCC_GE && pwdata[0] |=> st.gs[0])
    else $error("enable write did not set channel status");
  a_zero_noop: assert property (
    wr && (paddr == DCC_GE || paddr == DCC_GD) && !pwdata[0] && !st.gs[0] |=> !st.gs[0])
    else $error("zero bit write changed channel status");
  a_read_clear: assert property (
    rd && paddr == DCC_CH_BASE + 12'(DCC_CIS) && !move_done |=> st.cis[0] == 2'b00)
    else $error("status read did not clear pending bits");
  a_block_flag: assert property (
    $rose(st.cis[0][DCC_IRQ_BLK]) |-> $past(move_done) && $past(st.move_chan) == '0)
    else $error("end of block flag without a finished move");
  a_list_stop: assert property (
    st.eng == DCC_E_MOVE && st.last_desc && move_done |=> !st.fetch_req)
    else $error("fetch after the last descriptor");
  a_irq_gate: assert property (
    st.gie == '0 |-> !st.irq)
    else $error("irq raised with every channel gate closed");
  a_list_irq: assert property (
    $rose(st.cis[0][DCC_IRQ_LST]) |-> $past(st.list_mode) && $past(move_done))
    else $error("list end flag outside list mode");
  a_move_hold: assert property (
    st.move_req && !move_done |=> st.move_req && $stable(st.move_src))
    else $error("move request changed before done");

  c_start: cover property (wr && paddr == DCC_GE ##1 st.fetch_req);
  c_block: cover property (st.move_req && move_done ##1 st.irq);
  c_chain: cover property (st.eng == DCC_E_MOVE ##1 st.eng == DCC_E_FETCH);
  c_abort: cover property (st.abort ##[1:20] $fell(st.gs[st.cur]));

endmodule
`default_nettype wire

// >>> bench/dcc_far_model.sv
// dcc_far_model: descriptor memory and microblock mover behind the engine.
// assumes fetch_req/move_req are held until answered; lat sets answer delay.
`timescale 1ns/100ps
`default_nettype none
module dcc_far_model
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] lat,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_if,
  output logic fetch_ack,
  output logic [31:0] fetch_data,
  input wire logic move_req,
  input wire logic [1:0] move_chan,
  input wire logic [31:0] move_src,
  input wire logic [31:0] move_dst,
  output logic move_done
);
  logic [31:0] mem [0:31];
  logic [3:0] wait_c;
  int fetch_cnt, move_cnt;
  logic [31:0] first_addr, last_src, last_dst;
  logic [1:0] last_chan;
  logic first_if;

  // view 2 at 0x20 links to view 3 at 0x30; view 1 at 0x50 links to view 0 at 0x60
  initial
  begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    mem[8] = 32'h0000_0030;
    mem[9] = 32'h1900_0000;
    mem[10] = 32'h0000_00a0;
    mem[11] = 32'h0000_00b0;
    mem[13] = 32'h0000_0000;
    mem[14] = 32'h0000_00c0;
    mem[15] = 32'h0000_00d0;
    mem[16] = 32'h0000_0002;
    mem[20] = 32'h0000_0060;
    mem[21] = 32'h0100_0000;
    mem[22] = 32'h0000_00e0;
  end

  // outside the ack cycle the bus shows the inverse, never a stale word
  assign fetch_data = fetch_ack ? mem[fetch_addr[6:2]] : ~mem[fetch_addr[6:2]];

  // one answer at a time, after lat idle cycles
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_c <= 4'h0;
      fetch_ack <= 1'b0;
      move_done <= 1'b0;
    end
    else
    begin
      fetch_ack <= 1'b0;
      move_done <= 1'b0;
      if ((fetch_req && !fetch_ack) || (move_req && !move_done))
      begin
        wait_c <= (wait_c == lat) ? 4'h0 : wait_c + 4'h1;
        if (wait_c == lat && fetch_req)
        begin
          fetch_ack <= 1'b1;
          if (fetch_cnt == 0)
          begin
            first_addr <= fetch_addr;
            first_if <= fetch_if;
          end
          fetch_cnt <= fetch_cnt + 1;
        end
        else if (wait_c == lat)
        begin
          move_done <= 1'b1;
          last_src <= move_src;
          last_dst <= move_dst;
          last_chan <= move_chan;
          move_cnt <= move_cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/dcc_channel_control_bench.sv
// dcc_channel_control_bench: apb driven scenarios for the channel control.
// assumes the far model answers fetches and moves; one 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module dcc_channel_control_bench;
  import dcc_pkg::*;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fetch_addr, fetch_data, move_src, move_dst, q;
  logic fetch_req, fetch_if, fetch_ack, move_req, move_done;
  logic [1:0] move_chan;
  logic [3:0] lat;
  int bad_count, checks_done, f0, m0;

  dcc_channel_ctrl #(.NCH(4)) DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_if(fetch_if), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .move_req(move_req), .move_chan(move_chan),
    .move_src(move_src), .move_dst(move_dst), .move_done(move_done));
  dcc_far_model FAR (.clock(clock), .sys_rst(sys_rst), .lat(lat), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_if(fetch_if), .fetch_ack(fetch_ack),
    .fetch_data(fetch_data), .move_req(move_req), .move_chan(move_chan),
    .move_src(move_src), .move_dst(move_dst), .move_done(move_done));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask

  function automatic logic [11:0] ch(input int n, input logic [5:0] off);
    return 12'(DCC_CH_BASE * (n + 1) + {6'h00, off});
  endfunction

  task rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask

  // polling keeps the bus busy, which is how software sees completion
  task poll_clear(input logic [31:0] m);
    int n;
    for (n = 0; n < 300; n++)
    begin
      apb(1'b0, DCC_GS, 32'h0000_0000);
      if ((q & m) === 32'h0000_0000)
        return;
    end
    bad_count++;
    report_and_stop();
  endtask

  task wait_irq();
    int n;
    for (n = 0; n < 2000 && irq !== 1'b1; n++)
      @(posedge clock);
    if (irq !== 1'b1)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lat = 4'h4;
    bad_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rd("gs", DCC_GS, 32'h0000_0000);
    rd("gie", DCC_GIE, 32'h0000_0000);
    rd("unmapped", 12'hffc, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, pslverr});
    // single block on channel 0, no list
    rd("cis0 pre", ch(0, DCC_CIS), 32'h0000_0000);
    apb(1'b1, ch(0, DCC_CSA), 32'h0000_0100);
    apb(1'b1, ch(0, DCC_CDA), 32'h0000_0200);
    apb(1'b1, ch(0, DCC_CBC), 32'h0000_0003);
    apb(1'b1, ch(0, DCC_CNDC), 32'h0000_0000);
    apb(1'b1, ch(0, DCC_CIE), 32'h0000_0001);
    apb(1'b1, DCC_GIE, 32'h0000_0001);
    f0 = FAR.fetch_cnt;
    m0 = FAR.move_cnt;
    apb(1'b1, DCC_GE, 32'h0000_0001);
    rd("gs run", DCC_GS, 32'h0000_0001);
    wait_irq();
    chk("moves", 32'd3, FAR.move_cnt - m0);
    chk("no fetch", 32'd0, FAR.fetch_cnt - f0);
    chk("src", 32'h0000_0100, FAR.last_src);
    chk("dst", 32'h0000_0200, FAR.last_dst);
    rd("gs done", DCC_GS, 32'h0000_0000);
    rd("cis0", ch(0, DCC_CIS), 32'h0000_0001);
    rd("cis0 clr", ch(0, DCC_CIS), 32'h0000_0000);
    chk("irq low", 32'h0, {31'h0, irq});
    // channel 3 completes with its global gate closed
    apb(1'b1, ch(3, DCC_CBC), 32'h0000_0001);
    apb(1'b1, ch(3, DCC_CIE), 32'h0000_0001);
    apb(1'b1, DCC_GE, 32'h0000_0008);
    poll_clear(32'h0000_0008);
    chk("irq gated", 32'h0, {31'h0, irq});
    rd("cis3", ch(3, DCC_CIS), 32'h0000_0001);
    // two descriptor list on channel 1, views 2 then 3
    apb(1'b1, DCC_GIE, 32'h0000_0002);
    apb(1'b1, ch(1, DCC_CIE), 32'h0000_0002);
    apb(1'b1, ch(1, DCC_CNDA), 32'h0000_0021);
    apb(1'b1, ch(1, DCC_CNDC), 32'h0000_0017);
    apb(1'b1, ch(1, DCC_CBC), 32'h0000_0001);
    f0 = FAR.fetch_cnt;
    m0 = FAR.move_cnt;
    apb(1'b1, DCC_GE, 32'h0000_0002);
    wait_irq();
    rd("cis1", ch(1, DCC_CIS), 32'h0000_0003);
    chk("fetches", 32'd9, FAR.fetch_cnt - f0);
    chk("list moves", 32'd3, FAR.move_cnt - m0);
    chk("first addr", 32'h0000_0020, FAR.first_addr);
    chk("first if", 32'h1, {31'h0, FAR.first_if});
    chk("new src", 32'h0000_00c0, FAR.last_src);
    chk("new dst", 32'h0000_00d0, FAR.last_dst);
    chk("list chan", 32'h1, {30'h0, FAR.last_chan});
    rd("gs list", DCC_GS, 32'h0000_0000);
    chk("fetch stop", 32'd9, FAR.fetch_cnt - f0);
    // long block on channel 2, stopped early
    lat <= 4'hf;
    apb(1'b1, ch(2, DCC_CBC), 32'h0000_0064);
    m0 = FAR.move_cnt;
    apb(1'b1, DCC_GE, 32'h0000_0004);
    apb(1'b1, DCC_GD, 32'h0000_0000);
    rd("gs zero gd", DCC_GS, 32'h0000_0004);
    apb(1'b1, DCC_GE, 32'h0000_0000);
    apb(1'b1, DCC_GD, 32'h0000_0004);
    poll_clear(32'h0000_0004);
    chk("stopped", 32'h1, {31'h0, (FAR.move_cnt - m0) < 100});
    // channel 0 list, views 1 then 0, update bits clear so addresses stay
    apb(1'b1, ch(0, DCC_CSA), 32'h0000_0300);
    apb(1'b1, ch(0, DCC_CDA), 32'h0000_0400);
    apb(1'b1, ch(0, DCC_CBC), 32'h0000_0001);
    apb(1'b1, ch(0, DCC_CNDA), 32'h0000_0050);
    apb(1'b1, ch(0, DCC_CNDC), 32'h0000_0009);
    f0 = FAR.fetch_cnt;
    m0 = FAR.move_cnt;
    apb(1'b1, DCC_GE, 32'h0000_0001);
    poll_clear(32'h0000_0001);
    chk("view fetches", 32'd5, FAR.fetch_cnt - f0);
    chk("view moves", 32'd2, FAR.move_cnt - m0);
    chk("kept src", 32'h0000_0300, FAR.last_src);
    chk("kept dst", 32'h0000_0400, FAR.last_dst);
    chk("chan0", 32'h0, {30'h0, FAR.last_chan});
    rd("cis0 list", ch(0, DCC_CIS), 32'h0000_0003);
    report_and_stop();
  end
endmodule
`default_nettype wire
